// ---- hdl/umr_top.sv ----
// usage monitor readout registers, banked secure / non-secure
`timescale 1ns/1ps
`default_nettype none
module umr_top #(
    parameter int NUM_MON = 4,
    parameter int SCALE   = 8
) (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // register port (bank chosen by REG_NS)
    input  wire logic        REG_REQ,
    input  wire logic        REG_NS,
    input  wire logic        REG_WE,
    input  wire logic [11:0] REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    output logic      [31:0] REG_RDATA,
    output logic             REG_ACK,
    // cache usage updates from the monitor fabric
    input  wire logic        CSU_UPD,
    input  wire logic        CSU_UPD_NS,
    input  wire logic [15:0] CSU_UPD_MON,
    input  wire logic [30:0] CSU_UPD_BYTES,
    input  wire logic        CSU_UPD_RDY,
    // bandwidth byte events from the monitor fabric
    input  wire logic        BW_EVT,
    input  wire logic        BW_EVT_NS,
    input  wire logic [15:0] BW_EVT_MON,
    input  wire logic [15:0] BW_EVT_BYTES,
    // capture trigger
    input  wire logic        CAP_STB,
    input  wire logic        CAP_NS,
    // configuration levels ([1] non-secure bank, [0] secure bank)
    input  wire logic [1:0]  SCALE_EN,
    input  wire logic        MON_PRESENT,
    input  wire logic        CSU_PRESENT,
    input  wire logic        BW_PRESENT,
    input  wire logic        CSU_CAP_PRESENT,
    input  wire logic        BW_CAP_PRESENT
);
    localparam int IW = (NUM_MON > 1) ? $clog2(NUM_MON) : 1;
    localparam int RW = 31 + SCALE;

    // ==================================================================
    // storage, first index is the bank (0 secure, 1 non-secure)
    logic [15:0]   sel_q      [2];
    logic [30:0]   csu_cnt_q  [2][NUM_MON];
    logic          csu_not_ready_flag_q [2][NUM_MON];
    logic [30:0]   csu_snap_q [2][NUM_MON];
    logic          csu_snr_q  [2][NUM_MON];
    logic [RW-1:0] bw_raw_q   [2][NUM_MON];
    logic          bw_not_ready_flag_q  [2][NUM_MON];
    logic [30:0]   bw_snap_q  [2][NUM_MON];
    logic          bw_snr_q   [2][NUM_MON];

    logic              bank;
    logic [15:0]       cur_sel;
    logic              idx_ok;
    logic [IW-1:0]     idx;
    umr_pkg::umr_reg_t reg_sel;
    logic              wr;
    logic [31:0]       rdata_d;
    logic [30:0]       bw_val     [2][NUM_MON];

    // rounded, optionally scaled view of each raw byte total
    function automatic logic [30:0] scaled(input logic [RW-1:0] raw,
                                           input logic en);
        logic [RW:0] sum;
        sum = {1'b0, raw} + (RW+1)'(1 << (SCALE - 1));
        if (en) begin
            scaled = 31'(sum >> SCALE);
        end else begin
            scaled = raw[30:0];
        end
    endfunction

    // ==================================================================
    // decode: the bank picks page and selector together
    always_comb begin
        bank    = REG_NS;
        cur_sel = sel_q[bank];
        idx_ok  = 32'(cur_sel) < NUM_MON;
        idx     = cur_sel[IW-1:0];
        // absent registers fall to REG_NONE and act as reserved-zero
        case (REG_ADDR)
            umr_pkg::OFS_MONITOR_INDEX_FIELD:
                reg_sel = MON_PRESENT ? umr_pkg::REG_SELECT
                                      : umr_pkg::REG_NONE;
            umr_pkg::OFS_CSU:
                reg_sel = (MON_PRESENT && CSU_PRESENT)
                        ? umr_pkg::REG_CSU : umr_pkg::REG_NONE;
            umr_pkg::OFS_CSU_SNAP:
                reg_sel = (MON_PRESENT && CSU_PRESENT && CSU_CAP_PRESENT)
                        ? umr_pkg::REG_CSU_SNAP : umr_pkg::REG_NONE;
            umr_pkg::OFS_BW:
                reg_sel = (MON_PRESENT && BW_PRESENT)
                        ? umr_pkg::REG_BW : umr_pkg::REG_NONE;
            umr_pkg::OFS_BW_SNAP:
                reg_sel = (MON_PRESENT && BW_PRESENT && BW_CAP_PRESENT)
                        ? umr_pkg::REG_BW_SNAP : umr_pkg::REG_NONE;
            default:
                reg_sel = umr_pkg::REG_NONE;
        endcase
        wr = REG_REQ && REG_WE;
    end

    // scaled live bandwidth values, per bank setting
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            for (int m = 0; m < NUM_MON; m++) begin
                bw_val[b][m] = scaled(bw_raw_q[b][m], SCALE_EN[b]);
            end
        end
    end

    // ==================================================================
    // monitor index selectors, one per bank
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sel_q[0] <= umr_pkg::RST_SEL;
            sel_q[1] <= umr_pkg::RST_SEL;
        end else if (wr && reg_sel == umr_pkg::REG_SELECT) begin
            sel_q[bank] <= REG_WDATA[umr_pkg::SEL_MSB:0];
        end
    end

    // cache usage: live reading and its snapshot
    // a software write beats a fabric update of the same monitor
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            for (int b = 0; b < 2; b++) begin
                for (int m = 0; m < NUM_MON; m++) begin
                    csu_cnt_q[b][m]  <= umr_pkg::RST_COUNT;
                    csu_not_ready_flag_q[b][m] <= umr_pkg::RST_NOT_READY_FLAG;
                    csu_snap_q[b][m] <= umr_pkg::RST_COUNT;
                    csu_snr_q[b][m]  <= umr_pkg::RST_NOT_READY_FLAG;
                end
            end
        end else begin
            if (CSU_UPD && 32'(CSU_UPD_MON) < NUM_MON) begin
                csu_cnt_q[CSU_UPD_NS][CSU_UPD_MON[IW-1:0]]  <= CSU_UPD_BYTES;
                csu_not_ready_flag_q[CSU_UPD_NS][CSU_UPD_MON[IW-1:0]] <= !CSU_UPD_RDY;
            end
            if (wr && idx_ok && reg_sel == umr_pkg::REG_CSU) begin
                csu_cnt_q[bank][idx]  <= REG_WDATA[umr_pkg::CNT_MSB:0];
                csu_not_ready_flag_q[bank][idx] <= REG_WDATA[umr_pkg::NOT_READY_FLAG_BIT];
            end
            if (wr && idx_ok && reg_sel == umr_pkg::REG_CSU_SNAP) begin
                csu_snap_q[bank][idx] <= REG_WDATA[umr_pkg::CNT_MSB:0];
                csu_snr_q[bank][idx]  <= REG_WDATA[umr_pkg::NOT_READY_FLAG_BIT];
            end
            // flag and count move in one edge, never half-updated;
            // last, so a capture beats a write only in its own bank
            if (CAP_STB) begin
                for (int m = 0; m < NUM_MON; m++) begin
                    csu_snap_q[CAP_NS][m] <= csu_cnt_q[CAP_NS][m];
                    csu_snr_q[CAP_NS][m]  <= csu_not_ready_flag_q[CAP_NS][m];
                end
            end
        end
    end

    // bandwidth: raw byte total kept wide so scaling loses nothing
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            for (int b = 0; b < 2; b++) begin
                for (int m = 0; m < NUM_MON; m++) begin
                    bw_raw_q[b][m]  <= '0;
                    bw_not_ready_flag_q[b][m] <= umr_pkg::RST_NOT_READY_FLAG;
                    bw_snap_q[b][m] <= umr_pkg::RST_COUNT;
                    bw_snr_q[b][m]  <= umr_pkg::RST_NOT_READY_FLAG;
                end
            end
        end else begin
            if (BW_EVT && 32'(BW_EVT_MON) < NUM_MON) begin
                bw_raw_q[BW_EVT_NS][BW_EVT_MON[IW-1:0]] <=
                    bw_raw_q[BW_EVT_NS][BW_EVT_MON[IW-1:0]]
                    + RW'(BW_EVT_BYTES);
            end
            if (wr && idx_ok && reg_sel == umr_pkg::REG_BW) begin
                bw_raw_q[bank][idx] <= SCALE_EN[bank]
                    ? RW'({REG_WDATA[umr_pkg::CNT_MSB:0], SCALE'(0)})
                    : RW'(REG_WDATA[umr_pkg::CNT_MSB:0]);
                bw_not_ready_flag_q[bank][idx] <= REG_WDATA[umr_pkg::NOT_READY_FLAG_BIT];
            end
            if (wr && idx_ok && reg_sel == umr_pkg::REG_BW_SNAP) begin
                bw_snap_q[bank][idx] <= REG_WDATA[umr_pkg::CNT_MSB:0];
                bw_snr_q[bank][idx]  <= REG_WDATA[umr_pkg::NOT_READY_FLAG_BIT];
            end
            // copy the already scaled value; no rescale on capture
            if (CAP_STB) begin
                for (int m = 0; m < NUM_MON; m++) begin
                    bw_snap_q[CAP_NS][m] <= bw_val[CAP_NS][m];
                    bw_snr_q[CAP_NS][m]  <= bw_not_ready_flag_q[CAP_NS][m];
                end
            end
        end
    end

    // ==================================================================
    // read path; an out-of-range index reads zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (reg_sel)
            umr_pkg::REG_SELECT:   rdata_d = {16'h0000, cur_sel};
            umr_pkg::REG_CSU:      if (idx_ok)
                rdata_d = {csu_not_ready_flag_q[bank][idx], csu_cnt_q[bank][idx]};
            umr_pkg::REG_CSU_SNAP: if (idx_ok)
                rdata_d = {csu_snr_q[bank][idx], csu_snap_q[bank][idx]};
            umr_pkg::REG_BW:       if (idx_ok)
                rdata_d = {bw_not_ready_flag_q[bank][idx], bw_val[bank][idx]};
            umr_pkg::REG_BW_SNAP:  if (idx_ok)
                rdata_d = {bw_snr_q[bank][idx], bw_snap_q[bank][idx]};
            default:               rdata_d = 32'h0000_0000;
        endcase
    end

    // answer one cycle after each request, read or write
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            REG_RDATA <= 32'h0000_0000;
            REG_ACK   <= 1'h0;
        end else begin
            REG_ACK   <= REG_REQ;
            REG_RDATA <= (REG_REQ && !REG_WE) ? rdata_d : 32'h0000_0000;
        end
    end

    // ==================================================================
    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    sequence s_sel_write;
        REG_REQ && REG_WE && !REG_NS && reg_sel == umr_pkg::REG_SELECT;
    endsequence
    sequence s_quiet_capture;
        CAP_STB && !CAP_NS && !wr && !CSU_UPD && !BW_EVT;
    endsequence

    a_ack_timing: assert property (REG_REQ |=> REG_ACK)
        else $error("request not answered next cycle");
    a_absent_zero: assert property (
        REG_REQ && !REG_WE && !MON_PRESENT |=> REG_RDATA == 32'h0000_0000)
        else $error("absent register did not read zero");
    a_sel_hold: assert property (
        s_sel_write ##1 !(wr && reg_sel == umr_pkg::REG_SELECT && !REG_NS)
        |-> sel_q[0] == $past(REG_WDATA[15:0], 1))
        else $error("selector lost written index");
    a_csu_snap_pair: assert property (
        s_quiet_capture |=> {csu_snr_q[0][0], csu_snap_q[0][0]}
            == $past({csu_not_ready_flag_q[0][0], csu_cnt_q[0][0]}))
        else $error("cache snapshot torn or stale");
    a_bw_snap_flag: assert property (
        s_quiet_capture |=> bw_snr_q[0][0] == $past(bw_not_ready_flag_q[0][0]))
        else $error("bandwidth snapshot flag not copied");
    a_bw_snap_value: assert property (
        s_quiet_capture |=> bw_snap_q[0][0] == $past(bw_val[0][0]))
        else $error("bandwidth snapshot rescaled");
    a_bw_accumulate: assert property (
        BW_EVT && !BW_EVT_NS && BW_EVT_MON == 16'h0000 && !wr
        |=> bw_raw_q[0][0] == $past(bw_raw_q[0][0]) + RW'($past(BW_EVT_BYTES)))
        else $error("bandwidth bytes not accumulated");
    a_bank_apart: assert property (
        REG_REQ && REG_WE && REG_NS && !CSU_UPD && !CAP_STB
        |=> csu_cnt_q[0][0] == $past(csu_cnt_q[0][0]))
        else $error("non-secure write reached secure bank");
    a_read_not_ready_flag: assert property (
        REG_REQ && !REG_WE && reg_sel == umr_pkg::REG_BW && idx_ok
        |=> REG_RDATA[31] == $past(bw_not_ready_flag_q[bank][idx]))
        else $error("not-ready flag misreported");
endmodule // umr_top
`default_nettype wire

// ---- hdl/umr_pkg.sv ----
// shared constants for the usage monitor readout bank
package umr_pkg;
    // ==================================================================
    // frame offsets, identical in the secure and non-secure page
    localparam logic [11:0] OFS_MONITOR_INDEX_FIELD  = 12'h800;
    localparam logic [11:0] OFS_CSU      = 12'h840;
    localparam logic [11:0] OFS_CSU_SNAP = 12'h848;
    localparam logic [11:0] OFS_BW       = 12'h860;
    localparam logic [11:0] OFS_BW_SNAP  = 12'h868;
    // ==================================================================
    // field layout of the readout words
    localparam int NOT_READY_FLAG_BIT = 31;
    localparam int CNT_MSB  = 30;
    localparam int SEL_MSB  = 15;
    // ==================================================================
    // reset values
    localparam logic        RST_NOT_READY_FLAG  = 1'h1;
    localparam logic [30:0] RST_COUNT = 31'h0000_0000;
    localparam logic [15:0] RST_SEL   = 16'h0000;
    // ==================================================================
    // register decoded from an access
    typedef enum logic [2:0] {
        REG_NONE, REG_SELECT, REG_CSU, REG_CSU_SNAP, REG_BW, REG_BW_SNAP
    } umr_reg_t;
endpackage

// ---- sim/umr_top_tb.sv ----
// self-checking bench for the usage monitor readout bank
`timescale 1ns/1ps
`default_nettype none
module umr_top_tb;
    // ==================================================================
    // stimulus rows: bank, write, offset, write data, expected read data
    typedef struct packed {
        logic        ns;
        logic        we;
        logic [11:0] addr;
        logic [31:0] wd;
        logic [31:0] ex;
    } umr_row_t;
    logic        clk_sys, rst_n, reg_req, reg_ns, reg_we, reg_ack;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        csu_upd, csu_upd_ns, csu_upd_rdy, bw_evt, bw_evt_ns;
    logic [15:0] csu_upd_mon, bw_evt_mon, bw_evt_bytes;
    logic [30:0] csu_upd_bytes;
    logic        cap_stb, cap_ns, mon_present, csu_present, bw_present;
    logic        csu_cap_present, bw_cap_present;
    logic [1:0]  scale_en;
    int          error_cnt, cmp_count;
    umr_row_t    rows [11];
    // ==================================================================
    umr_top #(.NUM_MON(4), .SCALE(8)) dut (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .REG_REQ(reg_req),
        .REG_NS(reg_ns), .REG_WE(reg_we), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack),
        .CSU_UPD(csu_upd), .CSU_UPD_NS(csu_upd_ns),
        .CSU_UPD_MON(csu_upd_mon), .CSU_UPD_BYTES(csu_upd_bytes),
        .CSU_UPD_RDY(csu_upd_rdy), .BW_EVT(bw_evt), .BW_EVT_NS(bw_evt_ns),
        .BW_EVT_MON(bw_evt_mon), .BW_EVT_BYTES(bw_evt_bytes),
        .CAP_STB(cap_stb), .CAP_NS(cap_ns), .SCALE_EN(scale_en),
        .MON_PRESENT(mon_present), .CSU_PRESENT(csu_present),
        .BW_PRESENT(bw_present), .CSU_CAP_PRESENT(csu_cap_present),
        .BW_CAP_PRESENT(bw_cap_present));
    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // ==================================================================
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // one access; ack and data stand only in the cycle after the request
    task automatic acc(input logic ns, we, input logic [11:0] a,
                       input logic [31:0] wd, ex);
        @(posedge clk_sys);
        reg_req   <= 1'b1;
        reg_ns    <= ns;
        reg_we    <= we;
        reg_addr  <= a;
        reg_wdata <= wd;
        @(posedge clk_sys);
        reg_req <= 1'b0;
        @(negedge clk_sys);
        chk("reg_ack", 32'h0000_0001, {31'h0, reg_ack});
        chk($sformatf("rdata@%h", a), ex, reg_rdata);
    endtask
    task automatic csu(input logic [15:0] m, input logic [30:0] b,
                       input logic r);
        @(posedge clk_sys);
        csu_upd       <= 1'b1;
        csu_upd_mon   <= m;
        csu_upd_bytes <= b;
        csu_upd_rdy   <= r;
        @(posedge clk_sys);
        csu_upd <= 1'b0;
    endtask
    task automatic bw(input logic [15:0] m, b);
        @(posedge clk_sys);
        bw_evt       <= 1'b1;
        bw_evt_mon   <= m;
        bw_evt_bytes <= b;
        @(posedge clk_sys);
        bw_evt <= 1'b0;
    endtask
    // capture of the bank that cap_ns selects
    task automatic cap();
        @(posedge clk_sys);
        cap_stb <= 1'b1;
        @(posedge clk_sys);
        cap_stb <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard: an exhausted limit is a mismatch
    initial begin
        repeat (3000) @(posedge clk_sys);
        error_cnt++;
        print_verdict();
    end
    // ==================================================================
    // main sequence
    initial begin
        {reg_req, reg_ns, reg_we, reg_addr, reg_wdata} = '0;
        {csu_upd, csu_upd_ns, csu_upd_mon, csu_upd_bytes, csu_upd_rdy} = '0;
        {bw_evt, bw_evt_ns, bw_evt_mon, bw_evt_bytes, cap_stb, cap_ns} = '0;
        {mon_present, csu_present, bw_present} = 3'b111;
        {csu_cap_present, bw_cap_present} = 2'b11;
        scale_en = 2'b00;
        error_cnt = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        rows = '{
            '{1'b0, 1'b1, umr_pkg::OFS_MONITOR_INDEX_FIELD, 32'hFFFF_0002, 32'h0},
            '{1'b0, 1'b0, umr_pkg::OFS_MONITOR_INDEX_FIELD, 32'h0, 32'h0000_0002},
            '{1'b1, 1'b0, umr_pkg::OFS_MONITOR_INDEX_FIELD, 32'h0, 32'h0},
            '{1'b0, 1'b1, umr_pkg::OFS_CSU, 32'h8000_0123, 32'h0},
            '{1'b0, 1'b0, umr_pkg::OFS_CSU, 32'h0, 32'h8000_0123},
            '{1'b1, 1'b0, umr_pkg::OFS_CSU, 32'h0, 32'h8000_0000},
            '{1'b0, 1'b1, umr_pkg::OFS_BW, 32'h0000_0050, 32'h0},
            '{1'b0, 1'b0, umr_pkg::OFS_BW, 32'h0, 32'h0000_0050},
            '{1'b1, 1'b0, umr_pkg::OFS_BW, 32'h0, 32'h8000_0000},
            '{1'b0, 1'b0, umr_pkg::OFS_CSU_SNAP, 32'h0, 32'h8000_0000},
            '{1'b0, 1'b0, 12'h804, 32'h0, 32'h0}};
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        // banked selector, live and snapshot words, unmapped offset
        foreach (rows[i]) begin
            acc(rows[i].ns, rows[i].we, rows[i].addr, rows[i].wd,
                rows[i].ex);
        end
        csu(16'h0002, 31'h0000_1234, 1'b1);
        acc(0, 0, umr_pkg::OFS_CSU, 0, 32'h0000_1234);
        bw(16'h0002, 16'h0010);
        bw(16'h0002, 16'h0010);
        acc(0, 0, umr_pkg::OFS_BW, 0, 32'h0000_0070);
        cap();
        acc(0, 0, umr_pkg::OFS_CSU_SNAP, 0, 32'h0000_1234);
        acc(0, 0, umr_pkg::OFS_BW_SNAP, 0, 32'h0000_0070);
        bw(16'h0002, 16'h0010);
        acc(0, 0, umr_pkg::OFS_BW_SNAP, 0, 32'h0000_0070);
        acc(0, 0, umr_pkg::OFS_BW, 0, 32'h0000_0080);
        acc(1, 0, umr_pkg::OFS_BW_SNAP, 0, 32'h8000_0000);
        csu(16'h0002, 31'h0000_0055, 1'b0);
        cap();
        acc(0, 0, umr_pkg::OFS_CSU_SNAP, 0, 32'h8000_0055);
        // scaled reading: (0x80 + 0x80) >> 8 gives 1
        @(posedge clk_sys);
        scale_en <= 2'b01;
        acc(0, 0, umr_pkg::OFS_BW, 0, 32'h0000_0001);
        acc(1, 0, umr_pkg::OFS_BW, 0, 32'h8000_0000);
        cap();
        @(posedge clk_sys);
        scale_en <= 2'b00;
        acc(0, 0, umr_pkg::OFS_BW_SNAP, 0, 32'h0000_0001);
        // non-secure fabric traffic and capture leave the secure bank alone
        @(posedge clk_sys);
        {csu_upd_ns, bw_evt_ns, cap_ns} <= 3'b111;
        csu(16'h0000, 31'h0000_0321, 1'b1);
        bw(16'h0000, 16'h0040);
        cap();
        @(posedge clk_sys);
        {csu_upd_ns, bw_evt_ns, cap_ns} <= 3'b000;
        acc(1, 0, umr_pkg::OFS_CSU, 0, 32'h0000_0321);
        acc(1, 0, umr_pkg::OFS_CSU_SNAP, 0, 32'h0000_0321);
        acc(1, 0, umr_pkg::OFS_BW_SNAP, 0, 32'h8000_0040);
        acc(0, 0, umr_pkg::OFS_CSU_SNAP, 0, 32'h8000_0055);
        acc(1, 1, umr_pkg::OFS_CSU, 32'h0000_0777, 32'h0);
        acc(1, 0, umr_pkg::OFS_CSU, 0, 32'h0000_0777);
        acc(0, 0, umr_pkg::OFS_CSU, 0, 32'h8000_0055);
        // secure monitor 0 bytes feed the accumulate check
        bw(16'h0000, 16'h0005);
        // software writes to the snapshot words
        acc(0, 1, umr_pkg::OFS_CSU_SNAP, 32'h0000_0099, 32'h0);
        acc(0, 0, umr_pkg::OFS_CSU_SNAP, 0, 32'h0000_0099);
        acc(0, 1, umr_pkg::OFS_BW_SNAP, 32'h8000_0011, 32'h0);
        acc(0, 0, umr_pkg::OFS_BW_SNAP, 0, 32'h8000_0011);
        // absent registers read zero and drop writes
        @(posedge clk_sys);
        {bw_present, csu_cap_present, mon_present} <= 3'b000;
        acc(0, 1, umr_pkg::OFS_BW, 32'h0000_0007, 32'h0);
        acc(0, 0, umr_pkg::OFS_BW, 0, 32'h0);
        acc(0, 0, umr_pkg::OFS_CSU_SNAP, 0, 32'h0);
        acc(0, 0, umr_pkg::OFS_MONITOR_INDEX_FIELD, 0, 32'h0);
        @(posedge clk_sys);
        {bw_present, csu_cap_present, mon_present} <= 3'b111;
        acc(0, 0, umr_pkg::OFS_BW, 0, 32'h0000_0080);
        // cache usage support and bandwidth capture support hide their own words
        @(posedge clk_sys);
        {csu_present, bw_cap_present} <= 2'b00;
        acc(0, 0, umr_pkg::OFS_CSU, 0, 32'h0);
        acc(0, 0, umr_pkg::OFS_CSU_SNAP, 0, 32'h0);
        acc(0, 0, umr_pkg::OFS_BW_SNAP, 0, 32'h0);
        @(posedge clk_sys);
        {csu_present, bw_cap_present} <= 2'b11;
        // a scaled write is stored shifted up by SCALE, in raw byte units
        scale_en <= 2'b01;
        acc(0, 1, umr_pkg::OFS_BW, 32'h0000_0003, 32'h0);
        acc(0, 0, umr_pkg::OFS_BW, 0, 32'h0000_0003);
        @(posedge clk_sys);
        scale_en <= 2'b00;
        acc(0, 0, umr_pkg::OFS_BW, 0, 32'h0000_0300);
        // out-of-range monitor index reads zero
        acc(0, 1, umr_pkg::OFS_MONITOR_INDEX_FIELD, 32'h0000_0004, 32'h0);
        acc(0, 0, umr_pkg::OFS_CSU, 0, 32'h0);
        // reset in mid-run restores selector and not-ready state
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        acc(0, 0, umr_pkg::OFS_MONITOR_INDEX_FIELD, 0, 32'h0);
        acc(0, 0, umr_pkg::OFS_BW, 0, 32'h8000_0000);
        print_verdict();
    end
endmodule // umr_top_tb
`default_nettype wire
